// ---- rtl/cpt_chan_ctrl.sv ----
// channel test signal selection, phase calibration and result windows
`include "cpt_cfg.svh"
`default_nettype none
module cpt_chan_ctrl #(
    parameter int NCH = `CPT_NCH,
    parameter int MOD_DIV = `CPT_MOD_DIV
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // modulator
    input wire logic [NCH-1:0] mod_bit,
    output logic mod_clk_en,
    // channel configuration
    input wire cpt_pkg::cpt_osr_t osr_sel,
    input wire cpt_pkg::cpt_insel_t [NCH-1:0] input_select_field,
    input wire logic [NCH-1:0][`CPT_PH_W-1:0] phase_offset_field,
    // analog routing
    output cpt_pkg::cpt_insel_t [NCH-1:0] ain_route,
    output logic test_bit,
    // results
    output logic data_ready,
    output logic [NCH-1:0][`CPT_CNT_W-1:0] result
);
    import cpt_pkg::*;

    // ********************
    // modulator rate divider
    // ********************
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic mod_en;
    always_comb begin
        mod_en = (div_cnt == 8'(MOD_DIV - 1));
        next_div_cnt = mod_en ? 8'h00 : div_cnt + 8'h01;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end
    assign mod_clk_en = mod_en;

    // ********************
    // reference window counter
    // ********************
    logic [`CPT_CNT_W-1:0] osr_m1;
    logic [`CPT_CNT_W-1:0] osr_len;
    logic [`CPT_CNT_W-1:0] ref_cnt;
    logic [`CPT_CNT_W-1:0] next_ref_cnt;
    logic ref_end;
    logic next_data_ready;
    always_comb begin
        osr_len = `CPT_CNT_W'(`CPT_OSR_MIN) << osr_sel;
        osr_m1 = osr_len - `CPT_CNT_W'(1);
        ref_end = mod_en && (ref_cnt == osr_m1);
        next_ref_cnt = ref_cnt;
        if (mod_en) begin
            if (ref_cnt >= osr_m1) begin
                next_ref_cnt = '0;
            end else begin
                next_ref_cnt = ref_cnt + `CPT_CNT_W'(1);
            end
        end
        next_data_ready = ref_end;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ref_cnt <= '0;
            data_ready <= 1'b0;
        end else begin
            ref_cnt <= next_ref_cnt;
            data_ready <= next_data_ready;
        end
    end

    // ********************
    // shared test source
    // ********************
    logic [4:0] tst_acc;
    logic [4:0] next_tst_acc;
    logic [5:0] tst_sum;
    logic next_test_bit;
    logic short_bit;
    logic next_short_bit;
    always_comb begin
        tst_sum = {1'b0, tst_acc} + 6'(`CPT_TST_NUM);
        next_tst_acc = tst_acc;
        next_test_bit = test_bit;
        next_short_bit = short_bit;
        if (mod_en) begin
            next_short_bit = ~short_bit;
            if (tst_sum >= 6'(`CPT_TST_DEN)) begin
                next_tst_acc = 5'(tst_sum - 6'(`CPT_TST_DEN));
                next_test_bit = 1'b1;
            end else begin
                next_tst_acc = tst_sum[4:0];
                next_test_bit = 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tst_acc <= 5'h00;
            test_bit <= 1'b0;
            short_bit <= 1'b0;
        end else begin
            tst_acc <= next_tst_acc;
            test_bit <= next_test_bit;
            short_bit <= next_short_bit;
        end
    end

    // ********************
    // per channel windows
    // ********************
    logic [NCH-1:0] samp;
    logic [NCH-1:0] ch_end;
    logic signed [NCH-1:0][`CPT_PH_W-1:0] ph_eff;
    logic [NCH-1:0][`CPT_CNT_W:0] end_pos;
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            logic [`CPT_CNT_W-1:0] acc;
            logic [`CPT_CNT_W-1:0] next_acc;
            logic [`CPT_CNT_W-1:0] hold;
            logic [`CPT_CNT_W-1:0] next_hold;
            logic [`CPT_CNT_W-1:0] next_result;
            logic [`CPT_CNT_W-1:0] win_sum;
            logic [`CPT_CNT_W:0] raw_end;
            cpt_insel_t next_route;
            cpt_phase_clip u_clip (
                .osr_sel(osr_sel),
                .phase_in($signed(phase_offset_field[gi])),
                .phase_out(ph_eff[gi])
            );
            always_comb begin
                unique case (input_select_field[gi])
                    CPT_IN_NORMAL: samp[gi] = mod_bit[gi];
                    CPT_IN_SHORT: samp[gi] = short_bit;
                    CPT_IN_TEST_POS: samp[gi] = test_bit;
                    CPT_IN_TEST_NEG: samp[gi] = ~test_bit;
                endcase
                raw_end = {1'b0, osr_m1} + (`CPT_CNT_W+1)'($signed(ph_eff[gi]));
                if (raw_end > {1'b0, osr_m1}) begin
                    end_pos[gi] = raw_end - {1'b0, osr_len};
                end else begin
                    end_pos[gi] = raw_end;
                end
                ch_end[gi] = mod_en && ({1'b0, ref_cnt} == end_pos[gi]);
                win_sum = acc + `CPT_CNT_W'(samp[gi]);
                next_acc = acc;
                next_hold = hold;
                if (mod_en) begin
                    next_acc = ch_end[gi] ? '0 : win_sum;
                    if (ch_end[gi]) begin
                        next_hold = win_sum;
                    end
                end
                next_result = result[gi];
                if (ref_end) begin
                    next_result = ch_end[gi] ? win_sum : hold;
                end
                next_route = input_select_field[gi];
            end
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    acc <= '0;
                    hold <= '0;
                    result[gi] <= '0;
                    ain_route[gi] <= CPT_IN_NORMAL;
                end else begin
                    acc <= next_acc;
                    hold <= next_hold;
                    result[gi] <= next_result;
                    ain_route[gi] <= next_route;
                end
            end
        end
    endgenerate

    // ********************
    // assertions
    // ********************
    sequence s_ref_close;
        mod_en && (ref_cnt == osr_m1);
    endsequence
    sequence s_drdy_pulse;
        data_ready ##1 !data_ready;
    endsequence

    property p_route;
        @(posedge clk_sys) disable iff (!rst_b)
        ##1 (ain_route[0] == $past(input_select_field[0]));
    endproperty
    a_route: assert property (p_route) else $error("route lags select");

    property p_test_shared;
        @(posedge clk_sys) disable iff (!rst_b)
        (input_select_field[2] == CPT_IN_TEST_POS)
            && (input_select_field[3] == CPT_IN_TEST_NEG) |-> (samp[2] != samp[3]);
    endproperty
    a_test_shared: assert property (p_test_shared) else $error("test polarity");

    property p_test_level;
        @(posedge clk_sys) disable iff (!rst_b)
        mod_en && (tst_acc >= 5'(`CPT_TST_DEN - `CPT_TST_NUM)) |=> test_bit;
    endproperty
    a_test_level: assert property (p_test_level) else $error("test density");

    property p_clip_range;
        @(posedge clk_sys) disable iff (!rst_b)
        (osr_sel == 3'd0) |-> ($signed(ph_eff[0]) <= 10'sd63)
            && ($signed(ph_eff[0]) >= -10'sd64);
    endproperty
    a_clip_range: assert property (p_clip_range) else $error("phase range");

    property p_clip_big;
        @(posedge clk_sys) disable iff (!rst_b)
        (osr_sel >= 3'd3) |-> (ph_eff[1] == phase_offset_field[1]);
    endproperty
    a_clip_big: assert property (p_clip_big) else $error("wide range");

    property p_saturate;
        @(posedge clk_sys) disable iff (!rst_b)
        (osr_sel == 3'd1) && ($signed(phase_offset_field[0]) > 10'sd127)
            |-> (ph_eff[0] == 10'sd127);
    endproperty
    a_saturate: assert property (p_saturate) else $error("no saturation");

    property p_zero_phase;
        @(posedge clk_sys) disable iff (!rst_b)
        s_ref_close and (ph_eff[0] == '0) |-> ch_end[0];
    endproperty
    a_zero_phase: assert property (p_zero_phase) else $error("zero window");

    property p_aligned;
        @(posedge clk_sys) disable iff (!rst_b)
        (ph_eff[0] == ph_eff[1]) |-> (ch_end[0] == ch_end[1]);
    endproperty
    a_aligned: assert property (p_aligned) else $error("windows misaligned");

    property p_own_phase;
        @(posedge clk_sys) disable iff (!rst_b)
        s_ref_close and (ph_eff[1] == 10'sd1) |-> !ch_end[1] ##1 !ch_end[1];
    endproperty
    a_own_phase: assert property (p_own_phase) else $error("shift ignored");

    property p_drdy;
        @(posedge clk_sys) disable iff (!rst_b)
        s_ref_close |=> s_drdy_pulse;
    endproperty
    a_drdy: assert property (p_drdy) else $error("data ready");

    property p_window_len;
        @(posedge clk_sys) disable iff (!rst_b)
        (osr_sel == 3'd0) and s_ref_close |=> (ref_cnt == '0);
    endproperty
    a_window_len: assert property (p_window_len) else $error("window length");
endmodule // cpt_chan_ctrl
`default_nettype wire

// ---- rtl/cpt_cfg.svh ----
// constants for the channel phase and test signal block
`ifndef CPT_CFG_SVH
`define CPT_CFG_SVH
`define CPT_NCH 4
`define CPT_PH_W 10
`define CPT_CNT_W 15
`define CPT_OSR_MIN 128
`define CPT_HALF_MIN 64
`define CPT_PH_CAP 512
`define CPT_CAP_SEL 3
`define CPT_TST_NUM 17
`define CPT_TST_DEN 30
`define CPT_MOD_DIV 4
`endif

// ---- rtl/cpt_pkg.sv ----
// types for the channel phase and test signal block
`default_nettype none
package cpt_pkg;
    typedef enum logic [1:0] {
        CPT_IN_NORMAL = 2'h0,
        CPT_IN_SHORT = 2'h1,
        CPT_IN_TEST_POS = 2'h2,
        CPT_IN_TEST_NEG = 2'h3
    } cpt_insel_t;
    typedef logic [2:0] cpt_osr_t;
endpackage
`default_nettype wire

// ---- rtl/cpt_phase_clip.sv ----
// saturation of one signed phase value to the oversampling range
`include "cpt_cfg.svh"
`default_nettype none
module cpt_phase_clip (
    // oversampling ratio select
    input wire cpt_pkg::cpt_osr_t osr_sel,
    // phase value
    input wire logic signed [`CPT_PH_W-1:0] phase_in,
    output logic signed [`CPT_PH_W-1:0] phase_out
);
    import cpt_pkg::*;
    logic [11:0] half;
    logic signed [11:0] hi;
    logic signed [11:0] lo;
    logic signed [11:0] ph;
    always_comb begin
        if (osr_sel >= 3'(`CPT_CAP_SEL)) begin
            half = 12'(`CPT_PH_CAP);
        end else begin
            half = 12'(`CPT_HALF_MIN) << osr_sel;
        end
        hi = $signed(half) - 12'sh001;
        lo = -$signed(half);
        ph = 12'(phase_in);
        if (ph > hi) begin
            phase_out = hi[`CPT_PH_W-1:0];
        end else if (ph < lo) begin
            phase_out = lo[`CPT_PH_W-1:0];
        end else begin
            phase_out = ph[`CPT_PH_W-1:0];
        end
    end
endmodule // cpt_phase_clip
`default_nettype wire

// ---- verification/cpt_host_model.sv ----
// host side model: applies channel settings and reads conversions
`default_nettype none
module cpt_host_model (
    // clock and requested settings
    input wire logic clk_sys,
    input wire cpt_pkg::cpt_osr_t req_osr,
    input wire cpt_pkg::cpt_insel_t [3:0] req_sel,
    input wire logic [3:0][9:0] req_ph,
    // settings to the block
    output var cpt_pkg::cpt_osr_t osr_sel,
    output var cpt_pkg::cpt_insel_t [3:0] sel,
    output logic [3:0][9:0] ph,
    // readout
    input wire logic data_ready,
    input wire logic [3:0][14:0] result,
    output logic rd_stb,
    output logic [3:0][14:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        osr_sel = 3'h0;
        sel = {4{cpt_pkg::CPT_IN_NORMAL}};
        ph = '0;
        rd_stb = 1'b0;
        rd_data = '0;
    end
    always @(posedge clk_sys) begin
        #1;
        osr_sel = req_osr;
        sel = req_sel;
        ph = req_ph;
    end
    // all channels are read at the same data ready point
    always @(negedge clk_sys) begin
        rd_stb <= data_ready;
        if (data_ready === 1'b1) begin
            rd_data <= result;
        end
    end
endmodule // cpt_host_model
`default_nettype wire

// ---- verification/test_channel_phase_cal_testsig.sv ----
// self-checking bench for the channel phase and test signal block
`default_nettype none
module test_channel_phase_cal_testsig;
    timeunit 1ns;
    timeprecision 1ps;
    import cpt_pkg::*;
    typedef cpt_insel_t [3:0] cpt_sel4_t;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] mod_bit = 4'h0;
    logic mod_clk_en;
    logic test_bit;
    logic data_ready;
    logic rd_stb;
    cpt_osr_t req_osr = 3'h0;
    cpt_osr_t osr_sel;
    cpt_sel4_t req_sel = {4{CPT_IN_NORMAL}};
    cpt_sel4_t sel;
    cpt_sel4_t ain_route;
    logic [3:0][9:0] req_ph = '0;
    logic [3:0][9:0] ph;
    logic [3:0][14:0] result;
    logic [3:0][14:0] rd_data;
    logic [3:0][14:0] ev;
    logic [3:0][14:0] gv;
    logic [3:0] hist [0:4095];
    logic [3:0][14:0] exp_q [$];
    logic [15:0] lfsr = 16'h4AA7;
    logic [47:0] rv = '0;
    int n_tick = 0;
    int skip = 3;
    int err_count = 0;
    int compares = 0;
    int osr;
    int p;
    int t;
    always #5 clk_sys = ~clk_sys;
    cpt_chan_ctrl #(.NCH(4), .MOD_DIV(4)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .mod_bit(mod_bit), .mod_clk_en(mod_clk_en), .osr_sel(osr_sel),
        .input_select_field(sel), .phase_offset_field(ph), .ain_route(ain_route),
        .test_bit(test_bit), .data_ready(data_ready), .result(result));
    cpt_host_model i_host (.clk_sys(clk_sys), .req_osr(req_osr), .req_sel(req_sel),
        .req_ph(req_ph), .osr_sel(osr_sel), .sel(sel), .ph(ph), .data_ready(data_ready),
        .result(result), .rd_stb(rd_stb), .rd_data(rd_data));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int sat(input logic [9:0] v, input cpt_osr_t o);
        int h;
        int x;
        h = (64 << o) > 512 ? 512 : (64 << o);
        x = int'($signed(v));
        return (x < -h) ? -h : ((x > h - 1) ? h - 1 : x);
    endfunction
    function automatic logic [14:0] win(input int c, input int e, input int n);
        int s;
        s = 0;
        for (int i = e - n + 1; i <= e; i++) begin
            s += 32'(hist[i % 4096][c]);
        end
        return 15'(s);
    endfunction
    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wait_ready(output int k);
        k = 0;
        while (data_ready !== 1'b1 && k < 20000) begin
            @(posedge clk_sys);
            #2;
            k++;
        end
        if (k >= 20000) begin
            err_count++;
            $display("mismatch at %0t: no data ready", $time);
            tally_and_finish();
        end else begin
            @(posedge clk_sys);
            #2;
        end
    endtask
    task automatic apply(input cpt_osr_t o, input logic [7:0] s, input logic [39:0] f);
        int k;
        @(negedge clk_sys);
        req_osr = o;
        req_sel = cpt_sel4_t'(s);
        req_ph = f;
        skip = 3;
        repeat (3) @(posedge clk_sys);
        #2;
        check(15'(ain_route), 15'(s));
        for (int i = 0; i < 5; i++) begin
            wait_ready(k);
        end
        check(15'(k + 1), 15'(512 << o));
        $display("test done: osr_sel %0d", o);
    endtask
    // modulator bits and expected windows
    always @(posedge clk_sys) begin
        #1;
        if (data_ready === 1'b1 && skip > 0) begin
            skip--;
        end else if (data_ready === 1'b1) begin
            osr = 128 << osr_sel;
            for (int c = 0; c < 4; c++) begin
                p = sat(ph[c], osr_sel);
                p = (p <= 0) ? n_tick - 1 + p : n_tick - 1 - osr + p;
                ev[c] = (sel[c] == CPT_IN_NORMAL) ? win(c, p, osr) : 15'h7FFF;
                if (sel[c] == CPT_IN_SHORT) begin
                    ev[c] = 15'(osr / 2);
                end
            end
            exp_q.push_back(ev);
        end
        if (mod_clk_en === 1'b1) begin
            lfsr = nx(lfsr);
            mod_bit = lfsr[3:0];
            hist[n_tick % 4096] = lfsr[3:0];
            n_tick++;
        end
    end
    // result watcher
    always @(posedge clk_sys) begin
        if (rd_stb === 1'b1 && exp_q.size() > 0) begin
            gv = exp_q.pop_front();
            for (int c = 0; c < 4; c++) begin
                if (gv[c] !== 15'h7FFF) begin
                    check(rd_data[c], gv[c]);
                end
            end
            if (sel[2] == CPT_IN_TEST_POS && sel[3] == CPT_IN_TEST_NEG && ph[2] == ph[3]) begin
                check(rd_data[2] + rd_data[3], 15'(128 << osr_sel));
            end
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        @(negedge clk_sys);
        check(15'(data_ready), 15'h0000);
        check(15'(result[0]), 15'h0000);
        repeat (3) @(negedge clk_sys);
        t = 0;
        repeat (1200) begin
            @(negedge clk_sys);
            t += 32'(test_bit);
        end
        check(15'(t >= 679 && t <= 681), 15'h0001);
        $display("test done: test level");
        apply(3'h0, {CPT_IN_TEST_NEG, CPT_IN_TEST_POS, CPT_IN_SHORT, CPT_IN_NORMAL},
            {10'h3FB, 10'h3FB, 10'h001, 10'h064});
        apply(3'h1, 8'h00, {10'h200, 10'h07F, 10'h000, 10'h150});
        repeat (2) begin
            for (int i = 0; i < 3; i++) begin
                lfsr = nx(lfsr);
                rv = {rv[31:0], lfsr};
            end
            apply({2'h0, rv[40]}, rv[47:40], rv[39:0]);
        end
        apply(3'h4, 8'h00, {10'h200, 10'h1FF, 10'h000, 10'h3FF});
        tally_and_finish();
    end
endmodule // test_channel_phase_cal_testsig
`default_nettype wire
